/* File: rcrb_pkg.sv */
`default_nettype none
package rcrb_pkg;
	// ---------------------------------------------------------------
	// addresses
	// ---------------------------------------------------------------
	localparam logic [9:0] ADDR_FRONT_END  = 10'h100;
	localparam logic [9:0] ADDR_CCA_THRESH = 10'h105;
	localparam logic [9:0] ADDR_FREQ_LOW   = 10'h300;
	localparam logic [9:0] ADDR_FREQ_MID   = 10'h301;
	localparam logic [9:0] ADDR_FREQ_TOP   = 10'h302;
	localparam logic [9:0] ADDR_SIGNAL     = 10'h30C;
	localparam logic [9:0] ADDR_LINK       = 10'h30D;
	localparam logic [9:0] ADDR_RELOAD_HI  = 10'h318;
	localparam logic [9:0] ADDR_RELOAD_LO  = 10'h319;
	localparam logic [9:0] ADDR_SLOW_OSC   = 10'h31B;
	localparam logic [9:0] ADDR_AUX_POWER  = 10'h31E;
	localparam logic [9:0] ADDR_PIN_FUNC   = 10'h32C;
	localparam logic [9:0] ADDR_PIN_OUT    = 10'h32D;
	localparam logic [9:0] ADDR_BAND_OVR   = 10'h353;
	localparam logic [9:0] ADDR_CURR_OVR   = 10'h354;
	localparam logic [9:0] ADDR_OVR_EN     = 10'h355;
	localparam logic [9:0] ADDR_BAND_RES   = 10'h380;
	localparam logic [9:0] ADDR_CURR_RES   = 10'h381;
	localparam logic [9:0] ADDR_CONVERTER  = 10'h3AE;
	localparam logic [9:0] ADDR_MASK1_LO   = 10'h3C7;
	localparam logic [9:0] ADDR_MASK1_HI   = 10'h3C8;
	localparam logic [9:0] ADDR_MASK2_LO   = 10'h3C9;
	localparam logic [9:0] ADDR_MASK2_HI   = 10'h3CA;
	localparam logic [9:0] ADDR_FLAGS_LO   = 10'h3CB;
	localparam logic [9:0] ADDR_FLAGS_HI   = 10'h3CC;
	localparam logic [9:0] ADDR_DELIM      = 10'h3F4;
	localparam int         RW_COUNT        = 47;
	localparam logic [9:0] RW_ADDR [RW_COUNT] = '{
		ADDR_FRONT_END, ADDR_CCA_THRESH, 10'h106, 10'h107, 10'h108, 10'h109, 10'h10A,
		10'h10B, 10'h13E, ADDR_FREQ_LOW, ADDR_FREQ_MID, ADDR_FREQ_TOP, 10'h306,
		10'h313, 10'h314, 10'h315, 10'h316, 10'h317, ADDR_RELOAD_HI, ADDR_RELOAD_LO,
		10'h31A, ADDR_AUX_POWER, ADDR_PIN_FUNC, ADDR_PIN_OUT, 10'h33D, ADDR_BAND_OVR,
		ADDR_CURR_OVR, ADDR_OVR_EN, 10'h36E, 10'h36F, 10'h371, 10'h395, 10'h396,
		10'h39B, 10'h3A7, 10'h3A8, 10'h3A9, 10'h3AA, 10'h3B9, ADDR_MASK1_LO,
		ADDR_MASK1_HI, ADDR_MASK2_LO, ADDR_MASK2_HI, 10'h3E3, 10'h3E6, 10'h3F0,
		ADDR_DELIM};
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int         BIT_STOP_RAMP   = 7;
	localparam int         BIT_RX_AUTO     = 4;
	localparam int         BIT_TX_AUTO     = 3;
	localparam int         BIT_AMP_AUTO    = 2;
	localparam int         BIT_AMP_BIAS    = 4;
	localparam int         BIT_RX_PIN      = 6;
	localparam int         BIT_TX_PIN      = 5;
	localparam int         BIT_BAND_OVR_EN = 0;
	localparam int         BIT_CURR_OVR_EN = 1;
	localparam int         FLAG_CCA        = 8;
	localparam int         FREQ_TOP_BITS   = 2;
	localparam logic [7:0] RESET_ZERO      = 8'h00;
	localparam logic [7:0] RESET_CCA       = 8'hAB;
	localparam logic [7:0] RESET_MASK_LO   = 8'h02;
	localparam logic [7:0] RESET_DELIM     = 8'h00;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {RCRB_IDLE, RCRB_RX, RCRB_TX, RCRB_BUSY} rcrb_radio_state_type;
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} rcrb_host_req_type;
	typedef struct packed {
		rcrb_radio_state_type state;
		logic [15:0]          events;
		logic                 cca_done;
		logic [7:0]           signal_level;
		logic [7:0]           link_quality;
		logic [7:0]           slow_osc_status;
		logic [7:0]           converter_value;
		logic                 cal_done;
		logic [7:0]           cal_band;
		logic [7:0]           cal_current;
	} rcrb_radio_in_type;
	typedef struct packed {
		logic [RW_COUNT-1:0][7:0] regs;
		logic [15:0]              flags;
		logic [7:0]               band_result;
		logic [7:0]               current_result;
		logic                     cca_result;
		logic [7:0]               rdata;
		logic                     rvalid;
	} rcrb_state_type;
	function automatic logic [7:0] rcrb_reset_value(input logic [9:0] addr);
		case (addr)
			ADDR_CCA_THRESH: return RESET_CCA;
			ADDR_MASK1_LO:   return RESET_MASK_LO;
			ADDR_MASK2_LO:   return RESET_MASK_LO;
			ADDR_DELIM:      return RESET_DELIM;
			default:         return RESET_ZERO;
		endcase
	endfunction : rcrb_reset_value
endpackage : rcrb_pkg
`default_nettype wire

/* File: rcrb_register_bank.sv */
`default_nettype none
module rcrb_register_bank (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire rcrb_pkg::rcrb_host_req_type host_req,
	output logic [7:0]                      host_rdata,
	output logic                            host_rvalid,
	input  wire rcrb_pkg::rcrb_radio_in_type radio_in,
	output logic                            rx_switch_pin,
	output logic                            tx_switch_pin,
	output logic                            ext_amp_enable,
	output logic                            amp_stop_ramp_select,
	output logic [17:0]                     channel_freq,
	output logic [15:0]                     wake_timer_reload,
	output logic [7:0]                      frame_delim,
	output logic [7:0]                      vco_band,
	output logic [7:0]                      vco_current,
	output logic                            cca_result,
	output logic [15:0]                     event_flags,
	output logic                            irq_line1,
	output logic                            irq_line2
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	rcrb_pkg::rcrb_state_type q;
	rcrb_pkg::rcrb_state_type next_q;

	// ---------------------------------------------------------------
	// address lookup
	// ---------------------------------------------------------------
	// linear scan; synthesis folds it into a decoder
	function automatic int rw_index(input logic [9:0] addr);
		int found;
		found = -1;
		for (int i = 0; i < rcrb_pkg::RW_COUNT; i++) begin
			if (rcrb_pkg::RW_ADDR[i] == addr) begin
				found = i;
			end
		end
		return found;
	endfunction : rw_index

	function automatic logic [7:0] reg_at(
		input logic [rcrb_pkg::RW_COUNT-1:0][7:0] regs,
		input logic [9:0]                          addr
	);
		int idx;
		idx = rw_index(addr);
		if (idx < 0) begin
			return rcrb_pkg::RESET_ZERO;
		end
		return regs[idx];
	endfunction : reg_at

	// ---------------------------------------------------------------
	// register views
	// ---------------------------------------------------------------
	logic [7:0]  front_end_control;
	logic [7:0]  aux_power_enables;
	logic [7:0]  pin_function_setup;
	logic [7:0]  pin_output_value;
	logic [7:0]  vco_override_enable;
	logic [7:0]  channel_assess_threshold;
	logic [15:0] line1_mask;
	logic [15:0] line2_mask;
	logic [7:0]  freq_top;

	always_comb begin
		front_end_control        = reg_at(q.regs, rcrb_pkg::ADDR_FRONT_END);
		aux_power_enables        = reg_at(q.regs, rcrb_pkg::ADDR_AUX_POWER);
		pin_function_setup       = reg_at(q.regs, rcrb_pkg::ADDR_PIN_FUNC);
		pin_output_value         = reg_at(q.regs, rcrb_pkg::ADDR_PIN_OUT);
		vco_override_enable      = reg_at(q.regs, rcrb_pkg::ADDR_OVR_EN);
		channel_assess_threshold = reg_at(q.regs, rcrb_pkg::ADDR_CCA_THRESH);
		freq_top                 = reg_at(q.regs, rcrb_pkg::ADDR_FREQ_TOP);
		line1_mask = {reg_at(q.regs, rcrb_pkg::ADDR_MASK1_HI),
			reg_at(q.regs, rcrb_pkg::ADDR_MASK1_LO)};
		line2_mask = {reg_at(q.regs, rcrb_pkg::ADDR_MASK2_HI),
			reg_at(q.regs, rcrb_pkg::ADDR_MASK2_LO)};
	end

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	logic [7:0] read_value;

	always_comb begin
		case (host_req.addr)
			rcrb_pkg::ADDR_SIGNAL:    read_value = radio_in.signal_level;
			rcrb_pkg::ADDR_LINK:      read_value = radio_in.link_quality;
			rcrb_pkg::ADDR_SLOW_OSC:  read_value = radio_in.slow_osc_status;
			rcrb_pkg::ADDR_CONVERTER: read_value = radio_in.converter_value;
			rcrb_pkg::ADDR_BAND_RES:  read_value = q.band_result;
			rcrb_pkg::ADDR_CURR_RES:  read_value = q.current_result;
			rcrb_pkg::ADDR_FLAGS_LO:  read_value = q.flags[7:0];
			rcrb_pkg::ADDR_FLAGS_HI:  read_value = q.flags[15:8];
			default:                  read_value = reg_at(q.regs, host_req.addr);
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic [15:0] flag_clear;
	logic [15:0] flag_set;
	int          widx;

	always_comb begin
		next_q     = q;
		flag_clear = 16'h0000;
		flag_set   = radio_in.events;
		widx       = rw_index(host_req.addr);
		next_q.rvalid = host_req.read;
		if (host_req.read) begin
			next_q.rdata = read_value;
		end
		// read-only addresses never match widx, so writes there drop
		if (host_req.write && widx >= 0) begin
			next_q.regs[widx] = host_req.wdata;
		end
		if (host_req.write && host_req.addr == rcrb_pkg::ADDR_FLAGS_LO) begin
			flag_clear[7:0] = host_req.wdata;
		end
		if (host_req.write && host_req.addr == rcrb_pkg::ADDR_FLAGS_HI) begin
			flag_clear[15:8] = host_req.wdata;
		end
		if (radio_in.cca_done) begin
			flag_set[rcrb_pkg::FLAG_CCA] = 1'b1;
			next_q.cca_result = $signed(radio_in.signal_level)
				< $signed(channel_assess_threshold);
		end
		// set beats clear so an event in the clearing cycle survives
		next_q.flags = (q.flags & ~flag_clear) | flag_set;
		if (radio_in.cal_done) begin
			next_q.band_result    = radio_in.cal_band;
			next_q.current_result = radio_in.cal_current;
		end
		if (!reset_n) begin
			for (int i = 0; i < rcrb_pkg::RW_COUNT; i++) begin
				next_q.regs[i] = rcrb_pkg::rcrb_reset_value(rcrb_pkg::RW_ADDR[i]);
			end
			next_q.flags          = 16'h0000;
			next_q.band_result    = rcrb_pkg::RESET_ZERO;
			next_q.current_result = rcrb_pkg::RESET_ZERO;
			next_q.cca_result     = 1'b0;
			next_q.rdata          = rcrb_pkg::RESET_ZERO;
			next_q.rvalid         = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		q <= next_q;
	end

	// ---------------------------------------------------------------
	// front-end pins
	// ---------------------------------------------------------------
	// manual switch levels pass only when the pin is set up as an output
	always_comb begin
		amp_stop_ramp_select = front_end_control[rcrb_pkg::BIT_STOP_RAMP];
		if (front_end_control[rcrb_pkg::BIT_RX_AUTO]) begin
			rx_switch_pin = radio_in.state == rcrb_pkg::RCRB_RX;
		end else begin
			rx_switch_pin = pin_output_value[rcrb_pkg::BIT_RX_PIN]
				& pin_function_setup[rcrb_pkg::BIT_RX_PIN];
		end
		if (front_end_control[rcrb_pkg::BIT_TX_AUTO]) begin
			tx_switch_pin = radio_in.state == rcrb_pkg::RCRB_TX;
		end else begin
			tx_switch_pin = pin_output_value[rcrb_pkg::BIT_TX_PIN]
				& pin_function_setup[rcrb_pkg::BIT_TX_PIN];
		end
		if (front_end_control[rcrb_pkg::BIT_AMP_AUTO]) begin
			ext_amp_enable = radio_in.state == rcrb_pkg::RCRB_TX;
		end else begin
			ext_amp_enable = aux_power_enables[rcrb_pkg::BIT_AMP_BIAS];
		end
	end

	// ---------------------------------------------------------------
	// configuration outputs
	// ---------------------------------------------------------------
	always_comb begin
		// only the two low bits of the top byte reach the channel word
		channel_freq = {freq_top[rcrb_pkg::FREQ_TOP_BITS-1:0],
			reg_at(q.regs, rcrb_pkg::ADDR_FREQ_MID),
			reg_at(q.regs, rcrb_pkg::ADDR_FREQ_LOW)};
		wake_timer_reload = {reg_at(q.regs, rcrb_pkg::ADDR_RELOAD_HI),
			reg_at(q.regs, rcrb_pkg::ADDR_RELOAD_LO)};
		frame_delim = reg_at(q.regs, rcrb_pkg::ADDR_DELIM);
		if (vco_override_enable[rcrb_pkg::BIT_BAND_OVR_EN]) begin
			vco_band = reg_at(q.regs, rcrb_pkg::ADDR_BAND_OVR);
		end else begin
			vco_band = q.band_result;
		end
		if (vco_override_enable[rcrb_pkg::BIT_CURR_OVR_EN]) begin
			vco_current = reg_at(q.regs, rcrb_pkg::ADDR_CURR_OVR);
		end else begin
			vco_current = q.current_result;
		end
		cca_result  = q.cca_result;
		event_flags = q.flags;
		irq_line1   = |(q.flags & line1_mask);
		irq_line2   = |(q.flags & line2_mask);
		host_rdata  = q.rdata;
		host_rvalid = q.rvalid;
	end
endmodule : rcrb_register_bank
`default_nettype wire

/* File: rcrb_asserts.sv */
`default_nettype none
module rcrb_asserts (
	input wire logic                        core_clk,
	input wire logic                        reset_n,
	input wire rcrb_pkg::rcrb_host_req_type host_req,
	input wire logic [7:0]                  host_rdata,
	input wire logic                        host_rvalid,
	input wire rcrb_pkg::rcrb_radio_in_type radio_in,
	input wire logic                        rx_switch_pin,
	input wire logic                        tx_switch_pin,
	input wire logic                        ext_amp_enable,
	input wire logic                        amp_stop_ramp_select,
	input wire logic                        cca_result,
	input wire logic [15:0]                 event_flags,
	input wire logic                        irq_line1,
	input wire logic                        irq_line2
);
	// ---------------------------------------------------------------
	// shadows: the bank itself is hidden, so mirror host writes
	// ---------------------------------------------------------------
	logic [7:0] fe;
	logic [7:0] thr;
	logic       tx_st;
	assign tx_st = radio_in.state == rcrb_pkg::RCRB_TX;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fe <= 8'h00;
			thr <= 8'hAB;
		end else if (host_req.write) begin
			if (host_req.addr == rcrb_pkg::ADDR_FRONT_END) fe <= host_req.wdata;
			if (host_req.addr == rcrb_pkg::ADDR_CCA_THRESH) thr <= host_req.wdata;
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_fl_clr;
		host_req.write && host_req.addr == rcrb_pkg::ADDR_FLAGS_LO && radio_in.events == 16'h0000;
	endsequence
	a_read_answer: assert property (host_req.read |=> host_rvalid)
		else $error("read not answered");
	a_rvalid_pulse: assert property (!host_req.read |=> !host_rvalid)
		else $error("spurious read valid");
	a_unmapped_zero: assert property (host_req.read && host_req.addr == 10'h000 |=> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rx_auto: assert property (fe[4] |-> rx_switch_pin == (radio_in.state == rcrb_pkg::RCRB_RX))
		else $error("rx switch wrong in auto mode");
	a_tx_auto: assert property (fe[3] |-> tx_switch_pin == tx_st)
		else $error("tx switch wrong in auto mode");
	a_amp_auto: assert property (fe[2] |-> ext_amp_enable == tx_st)
		else $error("amplifier not enabled in transmit");
	a_ramp_select: assert property (amp_stop_ramp_select == fe[7])
		else $error("ramp select differs from register");
	a_flag_set: assert property (|radio_in.events |=> (event_flags & $past(radio_in.events)) == $past(radio_in.events))
		else $error("event flag not set");
	a_flag_clear: assert property (s_fl_clr |=> (event_flags[7:0] & $past(host_req.wdata)) == 8'h00)
		else $error("event flag not cleared");
	a_cca_result: assert property (radio_in.cca_done |=> cca_result == ($signed($past(radio_in.signal_level)) < $signed($past(thr))))
		else $error("clear channel result wrong");
	a_irq_quiet: assert property (event_flags == 16'h0000 |-> !irq_line1 && !irq_line2)
		else $error("interrupt without flag");
endmodule : rcrb_asserts
bind rcrb_register_bank rcrb_asserts u_chk (.core_clk, .reset_n, .host_req, .host_rdata,
	.host_rvalid, .radio_in, .rx_switch_pin, .tx_switch_pin, .ext_amp_enable,
	.amp_stop_ramp_select, .cca_result, .event_flags, .irq_line1, .irq_line2);
`default_nettype wire

/* File: rcrb_radio_model.sv */
`default_nettype none
module rcrb_radio_model (
	input  wire logic                       core_clk,
	output var rcrb_pkg::rcrb_radio_in_type radio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// radio controller: pulses last one cycle, driven at falling edge
	// ---------------------------------------------------------------
	initial begin
		radio_in = '0;
		radio_in.signal_level = 8'h5C;
		radio_in.link_quality = 8'h3D;
	end
	// small delay so combinational pins settle before the caller looks
	task automatic go(input rcrb_pkg::rcrb_radio_state_type s);
		@(negedge core_clk);
		radio_in.state = s;
		#1;
	endtask : go
	task automatic fire(input logic [15:0] e);
		@(negedge core_clk);
		radio_in.events = e;
		@(negedge core_clk);
		radio_in.events = 16'h0000;
	endtask : fire
	task automatic measure(input logic [7:0] lvl);
		@(negedge core_clk);
		radio_in.signal_level = lvl;
		radio_in.cca_done = 1'b1;
		@(negedge core_clk);
		radio_in.cca_done = 1'b0;
	endtask : measure
	task automatic calibrate(input logic [7:0] b, input logic [7:0] c);
		@(negedge core_clk);
		radio_in.cal_band = b;
		radio_in.cal_current = c;
		radio_in.cal_done = 1'b1;
		@(negedge core_clk);
		radio_in.cal_done = 1'b0;
		radio_in.cal_band = ~b;
		radio_in.cal_current = ~c;
	endtask : calibrate
endmodule : rcrb_radio_model
`default_nettype wire

/* File: rcrb_register_bank_tb.sv */
`default_nettype none
module rcrb_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                        core_clk, reset_n, host_rvalid, cca_result;
	logic                        rx_switch_pin, tx_switch_pin, ext_amp_enable;
	logic                        amp_stop_ramp_select, irq_line1, irq_line2;
	rcrb_pkg::rcrb_host_req_type host_req;
	rcrb_pkg::rcrb_radio_in_type radio_in;
	logic [7:0]                  host_rdata, frame_delim, vco_band, vco_current;
	logic [17:0]                 channel_freq;
	logic [15:0]                 wake_timer_reload, event_flags;
	int                          n_fail, tests_run, cycles;
	rcrb_register_bank dut (.core_clk, .reset_n, .host_req, .host_rdata, .host_rvalid,
		.radio_in, .rx_switch_pin, .tx_switch_pin, .ext_amp_enable, .amp_stop_ramp_select,
		.channel_freq, .wake_timer_reload, .frame_delim, .vco_band, .vco_current,
		.cca_result, .event_flags, .irq_line1, .irq_line2);
	rcrb_radio_model u_radio (.core_clk, .radio_in);
	// ---------------------------------------------------------------
	// clock, timeout, tasks
	// ---------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge core_clk);
		host_req = '{a, d, 1'b1, 1'b0};
		@(negedge core_clk);
		host_req.write = 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(negedge core_clk);
		host_req = '{a, 8'h00, 1'b0, 1'b1};
		@(negedge core_clk);
		host_req.read = 1'b0;
		chk({17'h00000, host_rvalid}, 18'h00001);
		chk({10'h000, host_rdata}, {10'h000, e});
	endtask : rd
	// ---------------------------------------------------------------
	// main sequence; all host writes made while the radio is idle
	// ---------------------------------------------------------------
	initial begin
		n_fail = 0;
		tests_run = 0;
		cycles = 0;
		reset_n = 1'b0;
		host_req = '0;
		repeat (3) @(negedge core_clk);
		reset_n = 1'b1;
		rd(10'h100, 8'h00);
		rd(10'h105, 8'hAB);
		rd(10'h3C7, 8'h02);
		rd(10'h3C9, 8'h02);
		rd(10'h3F4, 8'h00);
		wr(10'h300, 8'h5A);
		wr(10'h301, 8'hC3);
		wr(10'h302, 8'hFE);
		chk(channel_freq, 18'h2C35A);
		wr(10'h318, 8'h12);
		wr(10'h319, 8'h34);
		chk({2'h0, wake_timer_reload}, 18'h01234);
		wr(10'h3F4, 8'hA7);
		chk({10'h000, frame_delim}, 18'h000A7);
		wr(10'h30C, 8'hFF);
		rd(10'h30C, 8'h5C);
		wr(10'h30D, 8'hFF);
		rd(10'h30D, 8'h3D);
		wr(10'h000, 8'hFF);
		rd(10'h000, 8'h00);
		wr(10'h32C, 8'h60);
		wr(10'h32D, 8'h40);
		chk({16'h0000, rx_switch_pin, tx_switch_pin}, 18'h00002);
		wr(10'h32D, 8'h20);
		chk({16'h0000, rx_switch_pin, tx_switch_pin}, 18'h00001);
		wr(10'h32C, 8'h00);
		chk({16'h0000, rx_switch_pin, tx_switch_pin}, 18'h00000);
		wr(10'h31E, 8'h10);
		chk({17'h00000, ext_amp_enable}, 18'h00001);
		wr(10'h31E, 8'h00);
		wr(10'h100, 8'h1C);
		for (int s = 0; s < 4; s++) begin
			u_radio.go(rcrb_pkg::rcrb_radio_state_type'(s));
			chk({15'h0000, rx_switch_pin, tx_switch_pin, ext_amp_enable},
				{15'h0000, s == 1, s == 2, s == 2});
		end
		u_radio.go(rcrb_pkg::RCRB_IDLE);
		wr(10'h100, 8'h80);
		chk({17'h00000, amp_stop_ramp_select}, 18'h00001);
		u_radio.calibrate(8'h21, 8'h43);
		rd(10'h380, 8'h21);
		rd(10'h381, 8'h43);
		wr(10'h353, 8'h77);
		wr(10'h354, 8'h66);
		chk({2'h0, vco_band, vco_current}, 18'h02143);
		wr(10'h355, 8'h01);
		chk({2'h0, vco_band, vco_current}, 18'h07743);
		wr(10'h355, 8'h02);
		chk({2'h0, vco_band, vco_current}, 18'h02166);
		u_radio.fire(16'h8002);
		chk({2'h0, event_flags}, 18'h08002);
		rd(10'h3CB, 8'h02);
		rd(10'h3CC, 8'h80);
		chk({16'h0000, irq_line1, irq_line2}, 18'h00003);
		wr(10'h3C9, 8'h00);
		chk({16'h0000, irq_line1, irq_line2}, 18'h00002);
		wr(10'h3CB, 8'h02);
		rd(10'h3CB, 8'h00);
		rd(10'h3CC, 8'h80);
		chk({17'h00000, irq_line1}, 18'h00000);
		wr(10'h3CC, 8'h80);
		u_radio.measure(8'hA0);
		chk({17'h00000, cca_result}, 18'h00001);
		rd(10'h3CC, 8'h01);
		u_radio.measure(8'hAB);
		chk({17'h00000, cca_result}, 18'h00000);
		finish_test();
	end
endmodule : rcrb_register_bank_tb
`default_nettype wire
